// *** switch_input_defines.svh ***
// Offsets, field positions, reset values and timing counts of the switch-input reaction block.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
`ifndef SWITCH_INPUT_DEFINES_SVH
`define SWITCH_INPUT_DEFINES_SVH

`define CLK_PERIOD_NS 10
`define SEC_NS 1000000000
`define SEC_CYCLES (`SEC_NS / `CLK_PERIOD_NS)

`define ADDR_W 5
`define OFS_CTRL 5'h00
`define OFS_REACT 5'h04
`define OFS_LINK 5'h08
`define OFS_WAIT 5'h0C
`define OFS_PERIOD 5'h10
`define OFS_STATUS 5'h14

`define CTRL_SL_EN 0
`define CTRL_SCAN_EN 1
`define CTRL_CYC_EN 2
`define CTRL_COND_LO 3
`define CTRL_WR_FLAG 5
`define CTRL_UPD_FLAG 6
`define CTRL_OBJ_EN_LO 8
`define CTRL_W 11
`define CTRL_RST 11'h100

`define REACT_W 18
`define REACT_RST 18'h01048
`define LINK_W 15
`define LINK_RST 15'h0000

`define WAIT_W 15
`define WAIT_MAX 15'h7530
`define WAIT_RST 15'h0000
`define PERIOD_W 16
`define PERIOD_RST 16'h003C

`define LINK_OUT_FIRST 5'h01
`define LINK_OUT_LAST 5'h10
`define LINK_BAN_FIRST 5'h0B
`define LINK_BAN_LAST 5'h0D
`define LINK_SCN_FIRST 5'h11
`define LINK_SCN_LAST 5'h18

`endif

// *** switch_input_pkg.sv ***
// Types shared by the switch-input reaction block.
// Assumes the constants header is available for numeric values.
package switch_input_pkg;
   typedef enum logic [2:0] {
      REACT_ON = 3'h0,
      REACT_OFF = 3'h1,
      REACT_TOGGLE = 3'h2,
      REACT_NONE = 3'h3,
      REACT_STOP = 3'h4
   } react_type;

   typedef enum logic [1:0] {
      RCV_IDLE = 2'h0,
      RCV_WAIT = 2'h1,
      RCV_SCAN = 2'h3
   } recover_type;

   typedef struct packed {
      logic is_cond0;
      logic is_cond1;
   } cond_type;
endpackage

// *** switch_obj_if.sv ***
// Bundle between the reaction top and one switching object.
// Assumes one clock domain; all fields are plain levels or one-cycle pulses.
`timescale 1ns/1ps
interface switch_obj_if;
   logic ev0;
   logic ev1;
   switch_input_pkg::react_type react0;
   switch_input_pkg::react_type react1;
   logic to_output;
   logic fb;
   logic bus_ld;
   logic bus_val;
   logic value;
   logic upd;
   logic stop;
   modport obj(input ev0, ev1, react0, react1, to_output, fb, bus_ld, bus_val, output value, upd, stop);
   modport ctl(output ev0, ev1, react0, react1, to_output, fb, bus_ld, bus_val, input value, upd, stop);
endinterface

// *** switch_object.sv ***
// One 1-bit switching object: applies the configured reaction to event 0/1.
// Assumes events are one-cycle pulses and never high together.
`timescale 1ns/1ps
module switch_object #(
   parameter bit HAS_CYC = 1'b0
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   switch_obj_if.obj so
);
   logic value_ff, nxt_value;
   logic upd_ff, nxt_upd;
   logic stop_ff, nxt_stop;
   switch_input_pkg::react_type r;

   assign so.value = value_ff;
   assign so.upd = upd_ff;
   assign so.stop = stop_ff;

   always_comb begin
      r = so.ev1 ? so.react1 : so.react0;
      nxt_value = value_ff;
      nxt_upd = 1'b0;
      nxt_stop = 1'b0;
      if (so.ev0 || so.ev1) begin
         unique case (r)
            switch_input_pkg::REACT_ON: begin
               nxt_value = 1'b1;
               nxt_upd = 1'b1;
            end
            switch_input_pkg::REACT_OFF: begin
               nxt_value = 1'b0;
               nxt_upd = 1'b1;
            end
            switch_input_pkg::REACT_TOGGLE: begin
               // Linked output: follow its status feedback so both ends stay consistent
               nxt_value = so.to_output ? !so.fb : !value_ff;
               nxt_upd = 1'b1;
            end
            switch_input_pkg::REACT_STOP: begin
               nxt_stop = HAS_CYC;
            end
            default: begin
               nxt_value = value_ff;
            end
         endcase
      end else if (so.bus_ld) begin
         nxt_value = so.bus_val;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         value_ff <= 1'b0;
         upd_ff <= 1'b0;
         stop_ff <= 1'b0;
      end else begin
         value_ff <= nxt_value;
         upd_ff <= nxt_upd;
         stop_ff <= nxt_stop;
      end
   end
endmodule

// *** binary_input_switch_reaction.sv ***
// Reaction logic of one binary switch input driving three 1-bit switching objects.
// Assumes debounced contact level from a pin, short/long pulses and bus events from same-clock logic.
// What this block does
// - After bus voltage recovery wait 0 to 30000 s, then scan the contact and react as if it just changed.
// - That wait runs on its own and never adds to the separate send delay.
// - Object 1 reacts per event with ON, OFF, TOGGLE, none or stop cyclic, event 1 defaulting to OFF.
// - Reactions fire on short/long operations when discrimination is on, else on every edge.
// - Stop cyclic only acts when cyclic sending of object 1 is enabled.
// - A linked local output is updated in the same cycle as the object, with no group addressing.
// - TOGGLE with an output link loads the inverse of that output's status feedback.
// - Links to outputs L, M and N are refused.
// - A scenario link fires the odd scene on value 0 and the even scene on value 1.
// - Object 1 is resent cyclically every 1 to 65535 s, default 60 s.
// - A change, and bus recovery after the send delay, send at once and restart the cycle timer.
// - Cyclic resending is limited to value 1, value 0, or both by default.
// - Bus writes and updates to object 1 are refused unless their flags are set.
// - Objects 2 and 3 offer ON, OFF, TOGGLE or none without cyclic sending, event 1 defaulting to ON.
// - Without discrimination opening gives event 0 and closing gives event 1.
// - With discrimination a short operation gives event 0 and a long one gives event 1.
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "switch_input_defines.svh"
module binary_input_switch_reaction #(
   parameter int unsigned SEC_CYCLES = `SEC_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [`ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic contact_i,
   input wire logic short_op_i,
   input wire logic long_op_i,
   input wire logic bus_recovery_i,
   input wire logic send_delay_done_i,
   input wire logic bus_wr_i,
   input wire logic bus_resp_i,
   input wire logic bus_val_i,
   input wire logic [15:0] out_status_i,
   output logic [2:0] tx_req_o,
   output logic [2:0] tx_val_o,
   output logic out_upd_o,
   output logic [3:0] out_idx_o,
   output logic out_val_o,
   output logic scene_trig_o,
   output logic [4:0] scene_number_o
);
   // Refuses L, M, N and anything outside the offered list
   function automatic logic [4:0] legal_link(input logic [4:0] c);
      if ((c >= `LINK_BAN_FIRST && c <= `LINK_BAN_LAST) || c > `LINK_SCN_LAST) begin
         return 5'h00;
      end
      return c;
   endfunction

   function automatic logic is_out(input logic [4:0] c);
      return c >= `LINK_OUT_FIRST && c <= `LINK_OUT_LAST;
   endfunction

   // Reset release and contact synchroniser
   logic rst_s1_ff, rst_ff;
   logic con_s1_ff, con_s2_ff, con_d_ff;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_ff <= 1'b0;
         rst_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_ff <= rst_s1_ff;
      end
   end
   always_ff @(posedge mclk_i or negedge rst_ff) begin
      if (!rst_ff) begin
         con_s1_ff <= 1'b0;
         con_s2_ff <= 1'b0;
         con_d_ff <= 1'b0;
      end else begin
         con_s1_ff <= contact_i;
         con_s2_ff <= con_s1_ff;
         con_d_ff <= con_s2_ff;
      end
   end

   // Register file
   logic [`CTRL_W-1:0] ctrl_ff, nxt_ctrl;
   logic [`REACT_W-1:0] react_ff, nxt_react;
   logic [`LINK_W-1:0] link_ff, nxt_link;
   logic [`WAIT_W-1:0] wait_ff, nxt_wait;
   logic [`PERIOD_W-1:0] period_ff, nxt_period;
   logic wreq_ff, nxt_wreq;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [31:0] wd;
   logic [31:0] status;
   logic take;
   logic cyc_act_ff, nxt_cyc_act;
   switch_input_pkg::recover_type rcv_ff, nxt_rcv;
   logic [2:0] val;

   assign status = {27'h0000000, cyc_act_ff, rcv_ff != switch_input_pkg::RCV_IDLE, val};
   assign take = (avs_read_i || avs_write_i) && !wreq_ff;

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_react = react_ff;
      nxt_link = link_ff;
      nxt_wait = wait_ff;
      nxt_period = period_ff;
      nxt_rdata = rdata_ff;
      // One wait cycle: data is latched on the first edge and handed over on the next
      nxt_wreq = !((avs_read_i || avs_write_i) && wreq_ff);
      for (int i = 0; i < 4; i++) begin
         wd[i*8 +: 8] = avs_byteenable_i[i] ? avs_writedata_i[i*8 +: 8] : 8'h00;
      end
      if ((avs_read_i || avs_write_i) && wreq_ff) begin
         unique case (avs_address_i)
            `OFS_CTRL: nxt_rdata = {21'h000000, ctrl_ff};
            `OFS_REACT: nxt_rdata = {14'h0000, react_ff};
            `OFS_LINK: nxt_rdata = {17'h00000, link_ff};
            `OFS_WAIT: nxt_rdata = {17'h00000, wait_ff};
            `OFS_PERIOD: nxt_rdata = {16'h0000, period_ff};
            `OFS_STATUS: nxt_rdata = status;
            default: nxt_rdata = 32'h00000000;
         endcase
      end
      if (avs_write_i && take) begin
         unique case (avs_address_i)
            `OFS_CTRL: nxt_ctrl = (ctrl_ff & ~avs_writedata_i[`CTRL_W-1:0] & ~{{3{avs_byteenable_i[1]}},
               {8{avs_byteenable_i[0]}}}) | wd[`CTRL_W-1:0] | (ctrl_ff & avs_writedata_i[`CTRL_W-1:0]);
            `OFS_REACT: nxt_react = wd[`REACT_W-1:0];
            `OFS_LINK: begin
               for (int i = 0; i < 3; i++) begin
                  nxt_link[i*5 +: 5] = legal_link(wd[i*5 +: 5]);
               end
            end
            `OFS_WAIT: nxt_wait = (wd > {17'h00000, `WAIT_MAX}) ? `WAIT_MAX : wd[`WAIT_W-1:0];
            `OFS_PERIOD: nxt_period = (wd[`PERIOD_W-1:0] == 16'h0000) ? 16'h0001 : wd[`PERIOD_W-1:0];
            default: nxt_rdata = rdata_ff;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_ff) begin
      if (!rst_ff) begin
         ctrl_ff <= `CTRL_RST;
         react_ff <= `REACT_RST;
         link_ff <= `LINK_RST;
         wait_ff <= `WAIT_RST;
         period_ff <= `PERIOD_RST;
         wreq_ff <= 1'b1;
         rdata_ff <= 32'h00000000;
      end else begin
         ctrl_ff <= nxt_ctrl;
         react_ff <= nxt_react;
         link_ff <= nxt_link;
         wait_ff <= nxt_wait;
         period_ff <= nxt_period;
         wreq_ff <= nxt_wreq;
         rdata_ff <= nxt_rdata;
      end
   end
   assign avs_waitrequest_o = wreq_ff;
   assign avs_readdata_o = rdata_ff;

   // Seconds prescaler, restarted by recovery so the wait lasts whole seconds
   logic [31:0] pre_ff, nxt_pre;
   logic sec_tick;
   assign sec_tick = pre_ff == SEC_CYCLES - 1;
   assign nxt_pre = (sec_tick || bus_recovery_i) ? 32'h00000000 : pre_ff + 32'h00000001;

   // Recovery wait: its own counter, separate from the send-delay handshake
   logic [`WAIT_W-1:0] wcnt_ff, nxt_wcnt;
   logic scan;
   always_comb begin
      nxt_rcv = rcv_ff;
      nxt_wcnt = wcnt_ff;
      scan = 1'b0;
      unique case (rcv_ff)
         switch_input_pkg::RCV_IDLE: begin
            if (bus_recovery_i && ctrl_ff[`CTRL_SCAN_EN]) begin
               nxt_wcnt = wait_ff;
               nxt_rcv = switch_input_pkg::RCV_WAIT;
            end
         end
         switch_input_pkg::RCV_WAIT: begin
            if (wcnt_ff == '0) begin
               nxt_rcv = switch_input_pkg::RCV_SCAN;
            end else if (sec_tick) begin
               nxt_wcnt = wcnt_ff - 1'b1;
            end
         end
         switch_input_pkg::RCV_SCAN: begin
            scan = 1'b1;
            nxt_rcv = switch_input_pkg::RCV_IDLE;
         end
         default: nxt_rcv = switch_input_pkg::RCV_IDLE;
      endcase
   end

   // Event sources
   logic ev0, ev1, waiting;
   assign waiting = rcv_ff == switch_input_pkg::RCV_WAIT;
   always_comb begin
      if (scan) begin
         ev0 = !con_s2_ff;
         ev1 = con_s2_ff;
      end else if (waiting) begin
         // Inputs are inactive during the wait
         ev0 = 1'b0;
         ev1 = 1'b0;
      end else if (ctrl_ff[`CTRL_SL_EN]) begin
         ev0 = short_op_i;
         ev1 = long_op_i;
      end else begin
         ev0 = con_d_ff && !con_s2_ff;
         ev1 = !con_d_ff && con_s2_ff;
      end
   end

   // Switching objects
   logic [2:0] upd, stop;
   logic bus_ok;
   assign bus_ok = bus_wr_i && (bus_resp_i ? ctrl_ff[`CTRL_UPD_FLAG] : ctrl_ff[`CTRL_WR_FLAG]);
   for (genvar g = 0; g < 3; g++) begin : g_obj
      switch_obj_if so();
      logic en;
      assign en = ctrl_ff[`CTRL_OBJ_EN_LO + g];
      assign so.ev0 = en && ev0;
      assign so.ev1 = en && ev1;
      assign so.react0 = switch_input_pkg::react_type'(react_ff[g*6 +: 3]);
      assign so.react1 = switch_input_pkg::react_type'(react_ff[g*6+3 +: 3]);
      assign so.to_output = is_out(link_ff[g*5 +: 5]);
      assign so.fb = out_status_i[4'(link_ff[g*5 +: 5] - 5'h01)];
      assign so.bus_ld = (g == 0) && en && bus_ok;
      assign so.bus_val = bus_val_i;
      assign val[g] = so.value;
      assign upd[g] = so.upd;
      assign stop[g] = so.stop;
      switch_object #(.HAS_CYC(g == 0)) u_obj (
         .mclk_i(mclk_i),
         .rst_n_i(rst_ff),
         .so(so)
      );
   end

   // Cyclic sending of object 1, send-delay release and link outputs
   logic [`PERIOD_W-1:0] ccnt_ff, nxt_ccnt;
   logic pend_ff, nxt_pend;
   logic [2:0] nxt_tx;
   logic nxt_oupd, nxt_oval, nxt_strig;
   logic [3:0] nxt_oidx;
   logic [4:0] nxt_snum;
   logic [2:0] tx_ff, tval_ff;
   logic oupd_ff, oval_ff, strig_ff;
   logic [3:0] oidx_ff;
   logic [4:0] snum_ff;
   logic cyc_ok, restart;
   logic [4:0] lk;
   switch_input_pkg::cond_type cond;

   always_comb begin
      cond = switch_input_pkg::cond_type'(ctrl_ff[`CTRL_COND_LO +: 2]);
      cyc_ok = (!cond.is_cond1 || val[0]) && (!cond.is_cond0 || !val[0]);
      nxt_pend = (pend_ff || bus_recovery_i) && !send_delay_done_i;
      restart = upd[0] || (pend_ff && send_delay_done_i) || (bus_ok && ctrl_ff[`CTRL_OBJ_EN_LO]);
      nxt_tx = upd;
      nxt_tx[0] = upd[0] || (pend_ff && send_delay_done_i) ||
         (ctrl_ff[`CTRL_CYC_EN] && cyc_act_ff && cyc_ok && ccnt_ff <= 16'h0001 && sec_tick);
      nxt_ccnt = ccnt_ff;
      if (restart || (sec_tick && ccnt_ff <= 16'h0001)) begin
         nxt_ccnt = period_ff;
      end else if (sec_tick) begin
         nxt_ccnt = ccnt_ff - 16'h0001;
      end
      nxt_cyc_act = cyc_act_ff;
      if (stop[0] && ctrl_ff[`CTRL_CYC_EN]) begin
         nxt_cyc_act = 1'b0;
      end else if (restart) begin
         nxt_cyc_act = 1'b1;
      end
      // Object 1 wins when several linked objects change together
      nxt_oupd = 1'b0;
      nxt_oidx = oidx_ff;
      nxt_oval = oval_ff;
      nxt_strig = 1'b0;
      nxt_snum = snum_ff;
      for (int i = 2; i >= 0; i--) begin
         lk = link_ff[i*5 +: 5];
         if (upd[i] && is_out(lk)) begin
            nxt_oupd = 1'b1;
            nxt_oidx = 4'(lk - 5'h01);
            nxt_oval = val[i];
         end
         if (upd[i] && lk >= `LINK_SCN_FIRST && lk <= `LINK_SCN_LAST) begin
            nxt_strig = 1'b1;
            nxt_snum = 5'((lk - `LINK_SCN_FIRST) * 2 + 1) + {4'h0, val[i]};
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_ff) begin
      if (!rst_ff) begin
         pre_ff <= 32'h00000000;
         rcv_ff <= switch_input_pkg::RCV_IDLE;
         wcnt_ff <= '0;
         ccnt_ff <= `PERIOD_RST;
         pend_ff <= 1'b0;
         cyc_act_ff <= 1'b1;
         tx_ff <= 3'h0;
         tval_ff <= 3'h0;
         oupd_ff <= 1'b0;
         oidx_ff <= 4'h0;
         oval_ff <= 1'b0;
         strig_ff <= 1'b0;
         snum_ff <= 5'h00;
      end else begin
         pre_ff <= nxt_pre;
         rcv_ff <= nxt_rcv;
         wcnt_ff <= nxt_wcnt;
         ccnt_ff <= nxt_ccnt;
         pend_ff <= nxt_pend;
         cyc_act_ff <= nxt_cyc_act;
         tx_ff <= nxt_tx;
         tval_ff <= val;
         oupd_ff <= nxt_oupd;
         oidx_ff <= nxt_oidx;
         oval_ff <= nxt_oval;
         strig_ff <= nxt_strig;
         snum_ff <= nxt_snum;
      end
   end

   assign tx_req_o = tx_ff;
   assign tx_val_o = tval_ff;
   assign out_upd_o = oupd_ff;
   assign out_idx_o = oidx_ff;
   assign out_val_o = oval_ff;
   assign scene_trig_o = strig_ff;
   assign scene_number_o = snum_ff;
endmodule

// *** binary_input_switch_reaction_props.sv ***
// Checker on the top ports of the switch-input reaction block.
// Assumes one clock domain; bound to the top at the foot of this file.
`timescale 1ns/1ps
module switch_reaction_props (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic bus_recovery_i,
   input wire logic send_delay_done_i,
   input wire logic [2:0] tx_req_o,
   input wire logic [2:0] tx_val_o,
   input wire logic out_upd_o,
   input wire logic [3:0] out_idx_o,
   input wire logic out_val_o,
   input wire logic scene_trig_o,
   input wire logic [4:0] scene_number_o
);
   logic rec_pend_ff;
   logic nxt_rec_pend;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Only a send delay that follows a recovery obliges a send
   always_comb begin
      nxt_rec_pend = rec_pend_ff;
      if (bus_recovery_i) nxt_rec_pend = 1'h1;
      else if (send_delay_done_i) nxt_rec_pend = 1'h0;
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) rec_pend_ff <= 1'h0;
      else rec_pend_ff <= nxt_rec_pend;
   end
   a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   a_request_answered: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus request not answered in the next cycle");
   a_recovery_send: assert property (send_delay_done_i && rec_pend_ff |-> ##[1:3] tx_req_o[0])
      else $error("object one not sent after the recovery send delay");
   a_obj_change_sent: assert property (!$stable(tx_val_o[1]) |-> ##[0:1] tx_req_o[1])
      else $error("object two changed without a send");
   a_scene_in_range: assert property (scene_trig_o |-> (|tx_req_o) && scene_number_o inside {[5'h01:5'h10]})
      else $error("scene trigger out of range or without an object send");
   a_scene_parity: assert property (scene_trig_o && tx_req_o == 3'h2 |-> scene_number_o[0] != tx_val_o[1])
      else $error("scene parity does not follow the object value");
   a_out_with_object: assert property (out_upd_o |-> (|tx_req_o) && (tx_req_o != 3'h1 || out_val_o == tx_val_o[0]))
      else $error("output update not together with the object");
   a_out_not_banned: assert property (out_upd_o |-> !(out_idx_o inside {4'hA, 4'hB, 4'hC}))
      else $error("output update on a refused output");
endmodule

bind binary_input_switch_reaction switch_reaction_props u_props (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_waitrequest_o(avs_waitrequest_o), .bus_recovery_i(bus_recovery_i), .send_delay_done_i(send_delay_done_i),
   .tx_req_o(tx_req_o), .tx_val_o(tx_val_o), .out_upd_o(out_upd_o), .out_idx_o(out_idx_o),
   .out_val_o(out_val_o), .scene_trig_o(scene_trig_o), .scene_number_o(scene_number_o));

// *** bus_side_model.sv ***
// Far side: telegram counter, relay status feedback, scene sink and send delay.
// Assumes the block's clock; relay status follows an output update one cycle later.
`timescale 1ns/1ps
module bus_side_model #(
   parameter int SEND_DELAY = 40
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic bus_recovery_i,
   input wire logic [2:0] tx_req_i,
   input wire logic out_upd_i,
   input wire logic [3:0] out_idx_i,
   input wire logic out_val_i,
   input wire logic scene_trig_i,
   input wire logic [4:0] scene_number_i,
   output logic send_delay_done_o,
   output logic [15:0] out_status_o,
   output logic [2:0][15:0] sends_o,
   output logic [4:0] last_scene_o
);
   int dly;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dly <= 0;
         send_delay_done_o <= 1'h0;
         out_status_o <= '0;
         sends_o <= '0;
         last_scene_o <= '0;
      end else begin
         send_delay_done_o <= (dly == 1);
         dly <= bus_recovery_i ? SEND_DELAY : (dly > 0 ? dly - 1 : 0);
         if (out_upd_i) out_status_o[out_idx_i] <= out_val_i;
         if (scene_trig_i) last_scene_o <= scene_number_i;
         for (int i = 0; i < 3; i++) if (tx_req_i[i]) sends_o[i] <= sends_o[i] + 16'h0001;
      end
   end
endmodule

// *** tb_binary_input_switch_reaction.sv ***
// Self-checking bench for the switch-input reaction block.
// Assumes the bus-side model and the bound checker compile with it.
`timescale 1ns/1ps
`include "switch_input_defines.svh"
module tb_binary_input_switch_reaction;
   logic mclk_i;
   logic rst_n_i = 1'h0;
   logic [4:0] adr = '0;
   logic rd = 0, wr = 0, contact = 0, sop = 0, lop = 0, rec = 0, bwr = 0, bresp = 0, bval = 0;
   logic [31:0] wdat = '0, rdat, q;
   logic wreq, sdone, upd, oval, strig;
   logic [2:0] treq, tval;
   logic [3:0] oidx;
   logic [4:0] snum, scn;
   logic [15:0] ostat;
   logic [2:0][15:0] sends;
   int lk[5] = '{10, 11, 12, 13, 25};
   int err_count = 0;
   int total_checks = 0;
   binary_input_switch_reaction #(.SEC_CYCLES(20)) u_dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .contact_i(contact), .short_op_i(sop), .long_op_i(lop), .bus_recovery_i(rec),
      .send_delay_done_i(sdone), .bus_wr_i(bwr), .bus_resp_i(bresp), .bus_val_i(bval),
      .out_status_i(ostat), .tx_req_o(treq), .tx_val_o(tval), .out_upd_o(upd), .out_idx_o(oidx),
      .out_val_o(oval), .scene_trig_o(strig), .scene_number_o(snum));
   bus_side_model #(.SEND_DELAY(40)) u_far (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_recovery_i(rec), .tx_req_i(treq), .out_upd_i(upd),
      .out_idx_i(oidx), .out_val_i(oval), .scene_trig_i(strig), .scene_number_i(snum),
      .send_delay_done_o(sdone), .out_status_o(ostat), .sends_o(sends), .last_scene_o(scn));
   initial begin
      mclk_i = 1'h0;
      forever #5 mclk_i = ~mclk_i;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      adr <= a;
      wdat <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge mclk_i);
      end while (wreq !== 1'h0);
      q = rdat;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask
   // 0 contact level, 1 short, 2 long, 3 bus telegram, 4 bus recovery
   task automatic act(input int k, input logic c, input int n);
      @(posedge mclk_i);
      if (k == 0) contact <= c;
      if (k == 1) sop <= 1'h1;
      if (k == 2) lop <= 1'h1;
      if (k == 3) bval <= c;
      if (k == 3) bwr <= 1'h1;
      if (k == 4) rec <= 1'h1;
      @(posedge mclk_i);
      {sop, lop, bwr, rec} <= 4'h0;
      repeat (n) @(posedge mclk_i);
   endtask
   initial begin
      repeat (2000) @(posedge mclk_i);
      err_count++;
      $display("ERROR watchdog expected finish seen timeout");
      tally_and_finish();
   end
   initial begin
      logic [15:0] s;
      logic v, ex;
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'h1;
      repeat (4) @(posedge mclk_i);
      bus(0, `OFS_CTRL, '0);
      check("ctrl flags", q[6:5], 0);
      bus(0, `OFS_REACT, '0);
      check("react defaults", q & 32'h38E38, 32'h8);
      bus(0, `OFS_PERIOD, '0);
      check("period", q, 32'h3C);
      bus(0, 5'h1C, '0);
      check("unmapped", q, 0);
      bus(1, `OFS_WAIT, 32'h9C40);
      bus(0, `OFS_WAIT, '0);
      check("wait clamp", q, 32'h7530);
      bus(1, `OFS_PERIOD, 32'hFFFF);
      bus(0, `OFS_PERIOD, '0);
      check("period max", q, 32'hFFFF);
      // Every code on event 1 of objects 1 and 2; cyclic off so stop is inert
      bus(1, `OFS_CTRL, 32'h700);
      for (int o = 0; o < 2; o++) begin
         for (int c = 0; c < 5; c++) begin
            bus(1, `OFS_REACT, 32'h1B6DB & ~(32'h7 << (6 * o + 3)) | (32'(c) << (6 * o + 3)));
            s = sends[o];
            v = tval[o];
            act(0, 1, 12);
            ex = (c == 0) ? 1'h1 : (c == 1) ? 1'h0 : (c == 2) ? !v : v;
            check("object value", tval[o], ex);
            check("sends", sends[o] - s, c < 3);
            act(0, 0, 12);
            check("no reaction", sends[o] - s, c < 3);
         end
      end
      // Discrimination on: edges are silent, short gives event 0, long event 1
      bus(1, `OFS_CTRL, 32'h701);
      bus(1, `OFS_REACT, 32'h0821B);
      s = sends[1];
      act(0, 1, 12);
      check("edge ignored", sends[1] - s, 0);
      act(1, 0, 12);
      check("short op", tval[2:1], 3);
      act(2, 0, 12);
      check("long op", tval[2:1], 0);
      // Output link with toggle follows the inverted relay status
      bus(1, `OFS_CTRL, 32'h700);
      bus(1, `OFS_REACT, 32'h1B6D3);
      bus(1, `OFS_LINK, 32'h3);
      for (int i = 0; i < 2; i++) begin
         act(0, 0, 12);
         act(0, 1, 12);
         check("linked toggle", tval[0], !i);
         check("relay status", ostat[2], !i);
      end
      foreach (lk[i]) begin
         bus(1, `OFS_LINK, 32'(lk[i]));
         bus(0, `OFS_LINK, '0);
         check("link code", q[4:0], (lk[i] inside {[11:13]} || lk[i] > 24) ? 0 : lk[i]);
      end
      // Every scenario pair on object 2
      bus(1, `OFS_REACT, 32'h1B05B);
      for (int p = 0; p < 8; p++) begin
         bus(1, `OFS_LINK, 32'(17 + p) << 5);
         act(0, 0, 12);
         check("odd scene", scn, 2 * p + 1);
         act(0, 1, 12);
         check("even scene", scn, 2 * p + 2);
      end
      // Cyclic sending, period 2 s
      bus(1, `OFS_LINK, '0);
      bus(1, `OFS_PERIOD, 32'h2);
      bus(1, `OFS_REACT, 32'h1B6C1);
      bus(1, `OFS_CTRL, 32'h70C);
      act(0, 0, 12);
      s = sends[0];
      repeat (120) @(posedge mclk_i);
      check("cyclic only 1", sends[0] - s, 0);
      act(0, 1, 0);
      s = sends[0];
      repeat (106) @(posedge mclk_i);
      check("cyclic restart", sends[0] - s, 3);
      bus(1, `OFS_CTRL, 32'h714);
      s = sends[0];
      repeat (100) @(posedge mclk_i);
      check("cyclic only 0", sends[0] - s, 0);
      bus(1, `OFS_CTRL, 32'h704);
      s = sends[0];
      repeat (120) @(posedge mclk_i);
      check("cyclic both", sends[0] - s, 3);
      bus(1, `OFS_REACT, 32'h1B6C4);
      act(0, 0, 12);
      s = sends[0];
      repeat (100) @(posedge mclk_i);
      check("cyclic stopped", sends[0] - s, 0);
      // Bus telegrams refused until their flags are set
      act(3, 0, 6);
      check("write refused", tval[0], 1);
      bresp <= 1'h1;
      act(3, 0, 6);
      check("update refused", tval[0], 1);
      bus(1, `OFS_CTRL, 32'h724);
      bresp <= 1'h0;
      act(3, 0, 6);
      check("write taken", tval[0], 0);
      bus(1, `OFS_CTRL, 32'h744);
      bresp <= 1'h1;
      act(3, 1, 6);
      check("update taken", tval[0], 1);
      // Recovery: 1 s wait, send delay 40 cycles, never summed
      bus(1, `OFS_CTRL, 32'h702);
      bus(1, `OFS_WAIT, 32'h1);
      bus(1, `OFS_REACT, 32'h1B6C1);
      s = sends[0];
      act(4, 0, 20);
      check("still waiting", tval[0], 1);
      check("no early send", sends[0] - s, 0);
      repeat (28) @(posedge mclk_i);
      check("scan after wait", tval[0], 0);
      check("recovery sends", sends[0] - s, 2);
      tally_and_finish();
   end
endmodule
